// *** common/tfe_defs.svh ***
// offsets, field positions, reset values for the timer flag/event block
// assumes apb byte addressing with one 32-bit word per register
`ifndef TFE_DEFS_SVH
`define TFE_DEFS_SVH
`define TFE_OFF_INTEN 12'h00c
`define TFE_OFF_FLAGS 12'h010
`define TFE_OFF_SWEVG 12'h014
`define TFE_OFF_CH0CV 12'h034
`define TFE_OFF_CTRL 12'h040
`define TFE_BIT_UPD 0
`define TFE_BIT_CH0 1
`define TFE_BIT_CMT 5
`define TFE_BIT_TRG 6
`define TFE_BIT_BRK 7
`define TFE_BIT_OF0 9
`define TFE_BIT_TRIGGER_DMA_REQUEST_ENABLE 14
`define TFE_FLAG_MASK 32'h00001eff
`define TFE_SWEVG_MASK 32'h000000ff
`define TFE_INTEN_MASK 32'h00007fff
`define TFE_RST_VAL 32'h00000000
`endif

// *** common/tfe_pkg.sv ***
// types for the timer flag/event block
// assumes nothing of its surroundings
package tfe_pkg;
  typedef enum logic [1:0] {
    tfe_idle,
    tfe_setup,
    tfe_access
  } tfe_apb_st_t;
  typedef logic [3:0] tfe_chan_t;
endpackage

// *** tb/tb.sv ***
// self-checking bench for tfe_flags over apb
// assumes tfe_flags and its checker are compiled first
`timescale 1ns/10ps
module tb;
  logic pclk = '0;
  logic presetn = '0;
  logic psel = '0, penable = '0, pwrite = '0, se;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, timer_irq, update_request, commutation_load;
  logic primary_output_enable, commutation_shadow_select;
  logic [3:0] chan_input_mode = '0, chan_capture = '0;
  logic [3:0] chan_compare = '0, chan_event_request;
  logic [15:0] chan0_capture_value = 16'h1234;
  logic break_active = '0, trig_in = '0, trig_falling_active = '0;
  logic pause_mode = '0, commutation_event = '0, update_event = '0;
  logic primary_output_enable_set = '0;
  logic [5:0] dma_request;
  int err_count = 0, checks_done = 0;
  tfe_flags u_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .chan_input_mode(chan_input_mode),
    .chan_capture(chan_capture),
    .chan_compare(chan_compare),
    .chan0_capture_value(chan0_capture_value),
    .break_active(break_active),
    .trig_in(trig_in),
    .trig_falling_active(trig_falling_active),
    .pause_mode(pause_mode),
    .commutation_event(commutation_event),
    .update_event(update_event),
    .primary_output_enable_set(primary_output_enable_set),
    .primary_output_enable(primary_output_enable),
    .commutation_shadow_select(commutation_shadow_select),
    .commutation_load(commutation_load),
    .update_request(update_request),
    .chan_event_request(chan_event_request),
    .timer_irq(timer_irq),
    .dma_request(dma_request)
  );
  initial forever #50 pclk = ~pclk;
  task chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("Error %s exp %h got %h", n, e, s);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rc(input string n, input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, '0);
    chk(n, rd, e);
  endtask
  // one cycle of capture, compare, update and commutation pulses
  task ev(input logic [9:0] v);
    @(posedge pclk);
    {chan_capture, chan_compare, update_event, commutation_event} <= v;
    @(posedge pclk);
    {chan_capture, chan_compare, update_event, commutation_event} <= '0;
  endtask
  task t_rst;
    rc("flags", 12'h010, '0);
    rc("unmapped", 12'h020, '0);
    chk("slverr", se, 1'b1);
    xfer(1'b1, 12'h040, 32'h3);
    chk("primary_output_enable", primary_output_enable, 1'b1);
    chk("commutation_shadow_select", commutation_shadow_select, 1'b1);
    $display("t_rst end");
  endtask
  task t_hw;
    chan_input_mode <= 4'h5;
    ev({4'ha, 4'h5, 2'b00});
    rc("wrongmode", 12'h010, '0);
    ev({4'h5, 4'ha, 2'b11});
    rc("hwset", 12'h010, 32'h3f);
    xfer(1'b1, 12'h010, 32'h1efe);
    rc("clr0", 12'h010, 32'h3e);
    xfer(1'b1, 12'h010, '0);
    $display("t_hw end");
  endtask
  task t_ovc;
    chan_input_mode <= 4'hf;
    ev({4'hf, 4'h0, 2'b00});
    ev({4'hf, 4'h0, 2'b00});
    rc("ovc", 12'h010, 32'h1e1e);
    rc("cv", 12'h034, 32'h1234);
    rc("cvclr", 12'h010, 32'h1e1c);
    xfer(1'b1, 12'h010, '0);
    chan_input_mode <= '0;
    xfer(1'b1, 12'h014, 32'h2);
    rc("cvout", 12'h034, 32'h1234);
    rc("cvkeep", 12'h010, 32'h2);
    xfer(1'b1, 12'h010, '0);
    $display("t_ovc end");
  endtask
  task t_brk;
    break_active <= 1'b1;
    xfer(1'b1, 12'h010, '0);
    rc("brkset", 12'h010, 32'h80);
    chk("hold", primary_output_enable, '0);
    primary_output_enable_set <= 1'b1;
    @(posedge pclk);
    primary_output_enable_set <= '0;
    @(posedge pclk);
    chk("poenbrk", primary_output_enable, '0);
    break_active <= '0;
    xfer(1'b1, 12'h010, '0);
    rc("brkclr", 12'h010, '0);
    primary_output_enable_set <= 1'b1;
    @(posedge pclk);
    primary_output_enable_set <= '0;
    @(posedge pclk);
    chk("poenset", primary_output_enable, 1'b1);
    xfer(1'b1, 12'h040, 32'h3);
    xfer(1'b1, 12'h014, 32'h80);
    chk("brkpoen", primary_output_enable, '0);
    rc("break_strobe", 12'h010, 32'h80);
    xfer(1'b1, 12'h010, '0);
    $display("t_brk end");
  endtask
  task t_trg;
    trig_in <= 1'b1;
    rc("rise", 12'h010, 32'h40);
    xfer(1'b1, 12'h010, '0);
    trig_in <= '0;
    rc("fall", 12'h010, '0);
    trig_falling_active <= 1'b1;
    trig_in <= 1'b1;
    rc("selrise", 12'h010, '0);
    trig_in <= '0;
    rc("selfall", 12'h010, 32'h40);
    xfer(1'b1, 12'h010, '0);
    trig_falling_active <= '0;
    pause_mode <= 1'b1;
    trig_in <= 1'b1;
    rc("pauserise", 12'h010, 32'h40);
    xfer(1'b1, 12'h010, '0);
    trig_in <= '0;
    rc("pause", 12'h010, 32'h40);
    pause_mode <= '0;
    xfer(1'b1, 12'h010, '0);
    xfer(1'b1, 12'h014, 32'h40);
    rc("trigger_strobe", 12'h010, 32'h40);
    $display("t_trg end");
  endtask
  task t_irq;
    xfer(1'b1, 12'h014, '0);
    rc("zero", 12'h010, 32'h40);
    rc("evrd", 12'h014, '0);
    xfer(1'b1, 12'h00c, 32'h4101);
    xfer(1'b1, 12'h014, 32'h3f);
    rc("evg", 12'h010, 32'h7f);
    chk("irq", timer_irq, 1'b1);
    chk("dma", dma_request, 6'h21);
    xfer(1'b1, 12'h010, 32'h1efe);
    chk("irqoff", timer_irq, '0);
    chk("dmaoff", dma_request, 6'h20);
    xfer(1'b1, 12'h00c, 32'h3e00);
    chk("irqnone", timer_irq, '0);
    chk("dmach", dma_request, 6'h1f);
    $display("t_irq end");
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_rst;
    t_hw;
    t_ovc;
    t_brk;
    t_trg;
    t_irq;
    tally_and_finish;
  end
  // the tests need a few hundred cycles; this is ten thousand
  initial begin
    #1000000;
    err_count++;
    tally_and_finish;
  end
endmodule

// *** tb/tfe_flags_sva.sv ***
// assertions on strobes, output enable and readback of tfe_flags
// assumes it is bound to tfe_flags and sees its ports only
`timescale 1ns/10ps
module tfe_flags_sva #(
  parameter int NCH = 4
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic primary_output_enable_set,
  input logic break_active,
  input logic primary_output_enable,
  input logic commutation_shadow_select,
  input logic commutation_load,
  input logic update_request,
  input logic [NCH-1:0] chan_event_request
);
  wire rq = psel && penable;
  wire ev = rq && pwrite && paddr == 12'h014;
  wire wc = rq && pwrite && paddr == 12'h040;
  wire [NCH-1:0] chs = {NCH{ev}} & pwdata[NCH:1];
  wire poe = primary_output_enable;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_upd; update_request == (ev && pwdata[0]); endproperty
  a_upd: assert property (p_upd) else $error("upd strobe");
  property p_chn; chan_event_request == chs; endproperty
  a_chn: assert property (p_chn) else $error("chan strobe");
  property p_cmt; commutation_load == (ev && pwdata[5]); endproperty
  a_cmt: assert property (p_cmt) else $error("cmt strobe");
  property p_once; update_request |=> !update_request; endproperty
  a_once: assert property (p_once) else $error("strobe long");
  property p_brk; ev && pwdata[7] && !primary_output_enable_set |=> !poe; endproperty
  a_brk: assert property (p_brk) else $error("brk primary_output_enable");
  property p_hold; (break_active && !primary_output_enable_set)[*2] |=> !poe; endproperty
  a_hold: assert property (p_hold) else $error("primary_output_enable hold");
  property p_commutation_shadow_select;
    !$stable(commutation_shadow_select) |-> $past(wc);
  endproperty
  a_commutation_shadow_select: assert property (p_commutation_shadow_select) else $error("commutation_shadow_select");
  property p_evrd; rq && !pwrite && paddr == 12'h014 |-> prdata == '0;
  endproperty
  a_evrd: assert property (p_evrd) else $error("ev read");
  c_brk: cover property (ev && pwdata[7]);
  c_cmt: cover property (commutation_load);
  c_hold: cover property (break_active);
endmodule

bind tfe_flags tfe_flags_sva #(.NCH(NCH)) u_sva (.*);

// *** verilog/tfe_flags.sv ***
// status flags, software event strobes and request outputs of a timer
// assumes a zero-wait apb master and event pulses one cycle wide on pclk
`timescale 1ns/10ps
`include "tfe_defs.svh"

// Functional notes
// - channel 0 over-capture set on capture while its flag is still set
// - channels 1 to 3 have matching over-capture flags at bits 10-12
// - break flag set by active break; software clear only when inactive
// - trigger flag set per trigger event; pause mode uses both edges
// - commutation flag set on commutation event, held until cleared
// - channel flag set on capture in input mode, compare in output
// - reading channel 0 capture value clears its flag in input mode
// - channels 1 to 3 have matching capture/compare flags at bits 2-4
// - update flag set on update event, held until software clears it
// - event bits are write-one strobes, self clearing, zero does nothing
// - break strobe clears primary output enable and sets break flag
// - trigger strobe sets trigger flag and raises enabled requests
// - commutation strobe loads channel controls from shadow per select
// - per-source dma request enables; trigger enable at bit 14
module tfe_flags #(
  parameter int NCH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NCH-1:0] chan_input_mode,
  input wire logic [NCH-1:0] chan_capture,
  input wire logic [NCH-1:0] chan_compare,
  input wire logic [15:0] chan0_capture_value,
  input wire logic break_active,
  input wire logic trig_in,
  input wire logic trig_falling_active,
  input wire logic pause_mode,
  input wire logic commutation_event,
  input wire logic update_event,
  input wire logic primary_output_enable_set,
  output logic primary_output_enable,
  output logic commutation_shadow_select,
  output logic commutation_load,
  output logic update_request,
  output logic [NCH-1:0] chan_event_request,
  output logic timer_irq,
  output logic [5:0] dma_request
);
  // apb decode; zero wait state, every access answered at once
  logic wr_acc;
  logic rd_acc;
  logic hit_inten;
  logic hit_flags;
  logic hit_swevg;
  logic hit_ch0cv;
  logic hit_ctrl;
  logic hit_any;
  logic access_ok;
  assign wr_acc = access_ok & pwrite;
  assign rd_acc = access_ok & ~pwrite;
  assign hit_inten = paddr == `TFE_OFF_INTEN;
  assign hit_flags = paddr == `TFE_OFF_FLAGS;
  assign hit_swevg = paddr == `TFE_OFF_SWEVG;
  assign hit_ch0cv = paddr == `TFE_OFF_CH0CV;
  assign hit_ctrl = paddr == `TFE_OFF_CTRL;
  assign hit_any = hit_inten | hit_flags | hit_swevg | hit_ch0cv | hit_ctrl;
  assign pready = 1'b1;
  assign pslverr = access_ok & ~hit_any;

  // bus phase of the cycle that just ended; an access only counts when a
  // setup came before it, so a stray penable cannot fire a strobe
  tfe_pkg::tfe_apb_st_t apb_st_r;
  tfe_pkg::tfe_apb_st_t apb_st_nxt;
  always_comb begin
    apb_st_nxt = tfe_pkg::tfe_idle;
    case (apb_st_r)
      tfe_pkg::tfe_idle, tfe_pkg::tfe_access: begin
        if (psel & ~penable) begin
          apb_st_nxt = tfe_pkg::tfe_setup;
        end
      end
      tfe_pkg::tfe_setup: begin
        if (psel & penable) begin
          apb_st_nxt = tfe_pkg::tfe_access;
        end else if (psel) begin
          apb_st_nxt = tfe_pkg::tfe_setup;
        end
      end
      default: begin
        apb_st_nxt = tfe_pkg::tfe_idle;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_st_r <= tfe_pkg::tfe_idle;
    end else begin
      apb_st_r <= apb_st_nxt;
    end
  end
  assign access_ok = psel & penable & (apb_st_r == tfe_pkg::tfe_setup);

  // interrupt enables in bits 7:0, dma enables in bits 14:8
  logic [14:0] inten_r;
  logic primary_output_enable_r;
  logic commutation_shadow_select_r;
  logic [31:0] prdata_r;

  // event strobes exist only in the write cycle; reads return zero
  logic [7:0] sw_strobe;
  assign sw_strobe = (wr_acc & hit_swevg) ? pwdata[7:0] : 8'h00;

  logic flag_wr;
  logic [31:0] flag_clr;
  assign flag_wr = wr_acc & hit_flags;
  // a zero clears a flag, a one leaves it; reserved bits are ignored
  assign flag_clr = flag_wr ? (~pwdata & `TFE_FLAG_MASK) : 32'h0;

  // hardware set sources
  logic trig_hw;
  tfe_trig_edge u_trig (
    .pclk(pclk),
    .presetn(presetn),
    .trig_in(trig_in),
    .trig_falling_active(trig_falling_active),
    .pause_mode(pause_mode),
    .trig_event(trig_hw)
  );

  logic [NCH-1:0] cc_flag;
  logic [NCH-1:0] of_flag;
  logic [NCH-1:0] cc_set;
  logic [NCH-1:0] of_set;
  logic [NCH-1:0] cc_clr;
  logic [NCH-1:0] of_clr;
  logic [NCH-1:0] hw_cc;
  logic cv_read_clr;

  // capture value read clears the channel 0 flag only in input mode
  assign cv_read_clr = rd_acc & hit_ch0cv & chan_input_mode[0];

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      // input mode: capture; output mode: compare match
      assign hw_cc[g] = chan_input_mode[g] ? chan_capture[g] :
                        chan_compare[g];
      assign cc_set[g] = hw_cc[g] | sw_strobe[`TFE_BIT_CH0 + g];
      assign cc_clr[g] = flag_clr[`TFE_BIT_CH0 + g] |
                         ((g == 0) & cv_read_clr);
      // over-capture only for hardware captures landing on a set flag
      assign of_set[g] = chan_input_mode[g] & chan_capture[g] &
                         cc_flag[g];
      assign of_clr[g] = flag_clr[`TFE_BIT_OF0 + g];
      tfe_sticky u_cc (
        .pclk(pclk),
        .presetn(presetn),
        .set_i(cc_set[g]),
        .clr_i(cc_clr[g]),
        .flag_o(cc_flag[g])
      );
      tfe_sticky u_of (
        .pclk(pclk),
        .presetn(presetn),
        .set_i(of_set[g]),
        .clr_i(of_clr[g]),
        .flag_o(of_flag[g])
      );
    end
  endgenerate

  logic upd_flag;
  logic cmt_flag;
  logic trg_flag;
  logic brk_flag;
  logic upd_set;
  logic cmt_set;
  logic trg_set;
  logic brk_set;
  logic brk_clr;
  logic upd_clr;
  logic cmt_clr;
  logic trg_clr;
  assign upd_set = update_event | sw_strobe[`TFE_BIT_UPD];
  assign cmt_set = commutation_event | sw_strobe[`TFE_BIT_CMT];
  assign trg_set = trig_hw | sw_strobe[`TFE_BIT_TRG];
  assign brk_set = break_active | sw_strobe[`TFE_BIT_BRK];
  // clear is refused while the break input still holds its active level
  assign brk_clr = flag_clr[`TFE_BIT_BRK] & ~break_active;
  assign upd_clr = flag_clr[`TFE_BIT_UPD];
  assign cmt_clr = flag_clr[`TFE_BIT_CMT];
  assign trg_clr = flag_clr[`TFE_BIT_TRG];

  tfe_sticky u_upd (
    .pclk(pclk),
    .presetn(presetn),
    .set_i(upd_set),
    .clr_i(upd_clr),
    .flag_o(upd_flag)
  );
  tfe_sticky u_cmt (
    .pclk(pclk),
    .presetn(presetn),
    .set_i(cmt_set),
    .clr_i(cmt_clr),
    .flag_o(cmt_flag)
  );
  tfe_sticky u_trg (
    .pclk(pclk),
    .presetn(presetn),
    .set_i(trg_set),
    .clr_i(trg_clr),
    .flag_o(trg_flag)
  );
  tfe_sticky u_brk (
    .pclk(pclk),
    .presetn(presetn),
    .set_i(brk_set),
    .clr_i(brk_clr),
    .flag_o(brk_flag)
  );

  // bit 8 and bits 31:13 are reserved and read as zero
  logic [31:0] flags_word;
  assign flags_word = {19'h0, of_flag, 1'b0, brk_flag, trg_flag, cmt_flag,
                       cc_flag, upd_flag};

  // enable, primary output enable and shadow select registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inten_r <= 15'h0000;
    end else if (wr_acc & hit_inten) begin
      inten_r <= pwdata[14:0];
    end
  end

  // break wins over a software enable in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_output_enable_r <= 1'b0;
    end else if (brk_set) begin
      primary_output_enable_r <= 1'b0;
    end else if (wr_acc & hit_ctrl) begin
      primary_output_enable_r <= pwdata[0];
    end else if (primary_output_enable_set) begin
      primary_output_enable_r <= 1'b1;
    end
  end

  // shadow select is only held here; the channel block acts on it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      commutation_shadow_select_r <= 1'b0;
    end else if (wr_acc & hit_ctrl) begin
      commutation_shadow_select_r <= pwdata[1];
    end
  end

  assign primary_output_enable = primary_output_enable_r;
  assign commutation_shadow_select = commutation_shadow_select_r;
  // the channel block performs the shadow load, honouring the select
  assign commutation_load = sw_strobe[`TFE_BIT_CMT];
  assign update_request = sw_strobe[`TFE_BIT_UPD];
  assign chan_event_request = sw_strobe[`TFE_BIT_CH0 +: NCH];

  // level interrupt follows flags and enables, no own state
  logic [7:0] irq_src;
  assign irq_src = flags_word[7:0] & inten_r[7:0];
  assign timer_irq = |irq_src;

  // dma: update, ch0..ch3, commutation, trigger (index 14 = trigger)
  // commutation shares output bit 0 with update: the port has six lines
  logic [6:0] dma_all;
  assign dma_all = {trg_flag, cmt_flag, cc_flag, upd_flag} &
                   inten_r[`TFE_BIT_TRIGGER_DMA_REQUEST_ENABLE:8];
  assign dma_request = {dma_all[6], dma_all[4:0]} |
                       {5'h00, dma_all[5]};

  logic [31:0] rd_mux;
  assign rd_mux = hit_inten ? {17'h0, inten_r} :
                  hit_flags ? flags_word :
                  hit_ch0cv ? {16'h0, chan0_capture_value} :
                  hit_ctrl ? {30'h0, commutation_shadow_select_r, primary_output_enable_r} : `TFE_RST_VAL;

  // read word is taken at the end of setup and stands through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= `TFE_RST_VAL;
    end else if (psel & ~penable & ~pwrite) begin
      prdata_r <= rd_mux;
    end
  end
  assign prdata = prdata_r;
endmodule

// *** verilog/tfe_sticky.sv ***
// one sticky flag: hardware set beats any clear in the same cycle
// assumes clear is a one-cycle pulse qualified by the caller
`timescale 1ns/10ps
module tfe_sticky (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);
  logic flag_r;
  logic flag_nxt;
  assign flag_nxt = set_i | (flag_r & ~clr_i);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end
  assign flag_o = flag_r;
endmodule

// *** verilog/tfe_trig_edge.sv ***
// trigger edge detector: active edge, or both edges in pause mode
// assumes trig_in is synchronous to pclk
`timescale 1ns/10ps
module tfe_trig_edge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic trig_in,
  input wire logic trig_falling_active,
  input wire logic pause_mode,
  output logic trig_event
);
  logic prev_r;
  logic rise;
  logic fall;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= trig_in;
    end
  end
  assign rise = trig_in & ~prev_r;
  assign fall = ~trig_in & prev_r;
  // pause mode reacts to both edges so the count can stop and restart
  assign trig_event = pause_mode ? (rise | fall) :
                      (trig_falling_active ? fall : rise);
endmodule
